/* File: logic/pmcap_top.sv */
// Purpose: Power management capability registers of the card reader function
// Assumes: Config requests are synchronous to clk; sys_rst is the global reset
// Notes:   Read-only to the host; latency byte reloadable by the serial loader
//
// Overview of operation
// - Latency byte resets to 04h and changes only by a load from the serial loader.
// - The default latency asks for the bus about every 0.25 us, a very high priority.
// - Capability header bits 15..8, the next pointer, read 00h.
// - Capability header bits 7..0, the capability code, read 01h.
// - Capabilities bit 15 follows the cold-wake enable bit of general control 4Ch bit 4.
// - Capabilities bits 14..11 read 1111b for wake from D3hot, D2, D1 and D0.
// - Capabilities bit 10 reads one for Second_sleep_state_capable.
// - Capabilities bit 9 reads one for First_sleep_state_capable.
// - Aux current bits 8..6 read 000b when bit 15 is clear, else 001b for 55 mA.
// - Capabilities bit 5 reads zero, no special initialization needed.
// - Capabilities bit 4 is reserved and reads zero.
// - Capabilities bit 3 reads zero, no bus clock needed to raise a wake event.
// - Capabilities bits 2..0 read 010b for power spec revision 1.1.
// - The cold-wake enable bit is cleared by the global reset or by a general control write of zero.
`timescale 1ns/1ps
`include "pmcap_map.svh"
module pmcap_top #(
    parameter logic [7:0] LAT_RESET = `PMCAP_LAT_RST
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire pmcap_pkg::pmcap_addr_t cfg_addr,
    output pmcap_pkg::pmcap_dword_t cfg_rdata,
    output logic cfg_ack,
    output logic cfg_hit,
    input wire logic eeprom_lat_load,
    input wire pmcap_pkg::pmcap_byte_t eeprom_lat_data,
    input wire logic gctrl_wr,
    input wire logic gctrl_cold_wake_data,
    output logic cold_wake_enable_ctrl,
    output logic wake_from_cold_state_capable
);
    import pmcap_pkg::*;

    // Interval the latency byte is meant to convey, in clk cycles
    localparam int LAT_INTERVAL_CYC = `PMCAP_LAT_INTERVAL_CYC;

    pmcap_if cif ();

    logic cold_wake_r;
    logic cold_wake_nxt;
    pmcap_caps_s caps;
    pmcap_hdr_s hdr;

    // Shadow of general control bit; a function-level reset must not touch it
    always_comb begin
        cold_wake_nxt = cold_wake_r;
        if (gctrl_wr) begin
            cold_wake_nxt = gctrl_cold_wake_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cold_wake_r <= 1'b0;
        end else begin
            cold_wake_r <= cold_wake_nxt;
        end
    end

    always_comb begin
        hdr.next_ptr = `PMCAP_NEXT_PTR;
        hdr.capability_code = `PMCAP_CAP_CODE;
    end

    always_comb begin
        caps.cold_wake = cold_wake_r;
        caps.wake_source_states = `PMCAP_WAKE_SRC;
        caps.second_sleep_state_capable = 1'b1;
        caps.first_sleep_state_capable = 1'b1;
        caps.aux_current = cold_wake_r ? `PMCAP_AUX_55MA : `PMCAP_AUX_SELF;
        caps.dev_init = 1'b0;
        caps.rsvd = 1'b0;
        caps.wake_needs_bus_clock = 1'b0;
        caps.power_spec_revision = `PMCAP_SPEC_REV;
    end

    assign cif.hdr = hdr;
    assign cif.caps = caps;
    assign cold_wake_enable_ctrl = cold_wake_r;
    assign wake_from_cold_state_capable = cold_wake_r;

    // Latency default chosen for a 0.25 us need interval
    pmcap_lat #(
        .RESET_VAL(LAT_RESET)
    ) u_lat (
        .clk(clk),
        .sys_rst(sys_rst),
        .load_stb(eeprom_lat_load),
        .load_data(eeprom_lat_data),
        .cif(cif.lat_mp)
    );

    pmcap_rd u_rd (
        .clk(clk),
        .sys_rst(sys_rst),
        .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr),
        .cif(cif.rd_mp),
        .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack),
        .cfg_hit(cfg_hit)
    );

    property p_lat_reset;
        @(posedge clk)
        $fell(sys_rst) |-> cif.latency == `PMCAP_LAT_RST;
    endproperty
    a_lat_reset: assert property (p_lat_reset)
        else $error("latency byte not 04h after reset");

    property p_lat_interval;
        @(posedge clk)
        $fell(sys_rst) |-> (cif.latency == LAT_RESET) && (LAT_INTERVAL_CYC == 25);
    endproperty
    a_lat_interval: assert property (p_lat_interval)
        else $error("latency default or its 25 cycle interval is wrong");

    property p_hdr;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && cfg_addr[7:2] == `PMCAP_DW_CAP |=> cfg_rdata[15:8] == 8'h00;
    endproperty
    a_hdr: assert property (p_hdr)
        else $error("next capability pointer did not read 00h");

    property p_code;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && cfg_addr[7:2] == `PMCAP_DW_CAP |=> cfg_rdata[7:0] == 8'h01;
    endproperty
    a_code: assert property (p_code)
        else $error("capability code did not read 01h");

    property p_cold_follow;
        @(posedge clk) disable iff (sys_rst)
        gctrl_wr |=> (wake_from_cold_state_capable == $past(gctrl_cold_wake_data))
            && (caps.cold_wake == $past(gctrl_cold_wake_data));
    endproperty
    a_cold_follow: assert property (p_cold_follow)
        else $error("cold wake bit did not follow general control");

    property p_fixed;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && cfg_addr[7:2] == `PMCAP_DW_CAP
            |=> (cfg_rdata[30:25] == 6'h3F) && (cfg_rdata[21:16] == 6'h02);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed capability bits wrong");

    property p_aux;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && cfg_addr[7:2] == `PMCAP_DW_CAP
            |=> cfg_rdata[24:22] == (cfg_rdata[31] ? 3'h1 : 3'h0);
    endproperty
    a_aux: assert property (p_aux)
        else $error("aux current field does not match cold wake bit");

    property p_cold_clear;
        @(posedge clk) disable iff (sys_rst)
        $fell(cold_wake_r) |-> $past(gctrl_wr) && !$past(gctrl_cold_wake_data);
    endproperty
    a_cold_clear: assert property (p_cold_clear)
        else $error("cold wake bit cleared without reset or control write");

    property p_wr_noeffect;
        @(posedge clk) disable iff (sys_rst)
        cfg_wr && !eeprom_lat_load |=> $stable(cif.latency) && cfg_ack;
    endproperty
    a_wr_noeffect: assert property (p_wr_noeffect)
        else $error("host write altered latency or was not acknowledged");
endmodule // pmcap_top

/* File: logic/pmcap_map.svh */
// Purpose: Offsets, field positions, reset values and timing of the power capability bank
// Assumes: Byte offsets in function configuration space, dword reads
// Notes:   Macros only; included by bare name
`ifndef PMCAP_MAP_SVH
`define PMCAP_MAP_SVH

// Register byte offsets
`define PMCAP_OFS_LATENCY 8'h3E
`define PMCAP_OFS_CAP_HDR 8'h44
`define PMCAP_OFS_CAPS 8'h46
`define PMCAP_OFS_GEN_CTRL 8'h4C

// Aligned dwords holding the registers
`define PMCAP_DW_LATENCY 6'h0F
`define PMCAP_DW_CAP 6'h11

// Byte lane positions inside those dwords
`define PMCAP_LANE_LATENCY 16
`define PMCAP_LANE_CAP_HDR 0
`define PMCAP_LANE_CAPS 16

// Reset and fixed values
`define PMCAP_LAT_RST 8'h04
`define PMCAP_NEXT_PTR 8'h00
`define PMCAP_CAP_CODE 8'h01
`define PMCAP_WAKE_SRC 4'hF
`define PMCAP_AUX_SELF 3'h0
`define PMCAP_AUX_55MA 3'h1
`define PMCAP_SPEC_REV 3'h2
`define PMCAP_CAPS_RST 16'h7E02

// General control field feeding the cold-wake bit
`define PMCAP_GCTRL_COLD_BIT 4

// Arbitration interval the default latency advertises
`define PMCAP_LAT_INTERVAL_NS 250
`define PMCAP_CLK_PERIOD_NS 10
`define PMCAP_LAT_INTERVAL_CYC (`PMCAP_LAT_INTERVAL_NS / `PMCAP_CLK_PERIOD_NS)

`endif

/* File: logic/pmcap_pkg.sv */
// Purpose: Types shared by the power capability bank
// Assumes: Nothing beyond the map header
// Notes:   Field layout of the capabilities word, msb first
package pmcap_pkg;
    typedef logic [7:0] pmcap_byte_t;
    typedef logic [31:0] pmcap_dword_t;
    typedef logic [7:0] pmcap_addr_t;

    typedef struct packed {
        logic cold_wake;
        logic [3:0] wake_source_states;
        logic second_sleep_state_capable;
        logic first_sleep_state_capable;
        logic [2:0] aux_current;
        logic dev_init;
        logic rsvd;
        logic wake_needs_bus_clock;
        logic [2:0] power_spec_revision;
    } pmcap_caps_s;

    typedef struct packed {
        logic [7:0] next_ptr;
        logic [7:0] capability_code;
    } pmcap_hdr_s;
endpackage

/* File: logic/pmcap_if.sv */
// Purpose: Carrier of register contents between the bank's own modules
// Assumes: Single clock
// Notes:   Latency comes from the holding module, the rest from the top
`timescale 1ns/1ps
interface pmcap_if;
    import pmcap_pkg::*;
    pmcap_byte_t latency;
    pmcap_hdr_s hdr;
    pmcap_caps_s caps;
    modport lat_mp (output latency);
    modport top_mp (output hdr, output caps);
    modport rd_mp (input latency, input hdr, input caps);
endinterface

/* File: logic/pmcap_lat.sv */
// Purpose: Holds the bus latency limit byte
// Assumes: Load strobe from the serial configuration loader, one cycle
// Notes:   Host writes never reach this module
`timescale 1ns/1ps
`include "pmcap_map.svh"
module pmcap_lat #(
    parameter logic [7:0] RESET_VAL = `PMCAP_LAT_RST
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load_stb,
    input wire pmcap_pkg::pmcap_byte_t load_data,
    pmcap_if.lat_mp cif
);
    import pmcap_pkg::*;

    pmcap_byte_t bus_latency_limit_r;
    pmcap_byte_t bus_latency_limit_nxt;

    always_comb begin
        bus_latency_limit_nxt = bus_latency_limit_r;
        if (load_stb) begin
            bus_latency_limit_nxt = load_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_latency_limit_r <= RESET_VAL;
        end else begin
            bus_latency_limit_r <= bus_latency_limit_nxt;
        end
    end

    assign cif.latency = bus_latency_limit_r;

    property p_lat_load;
        @(posedge clk) disable iff (sys_rst)
        load_stb |=> (bus_latency_limit_r == $past(load_data));
    endproperty
    a_lat_load: assert property (p_lat_load)
        else $error("latency byte did not take the loader value");

    property p_lat_hold;
        @(posedge clk) disable iff (sys_rst)
        !load_stb |=> $stable(bus_latency_limit_r);
    endproperty
    a_lat_hold: assert property (p_lat_hold)
        else $error("latency byte changed without a loader strobe");
endmodule // pmcap_lat

/* File: logic/pmcap_rd.sv */
// Purpose: Answers configuration reads and writes aimed at the bank
// Assumes: One request per cycle at most, dword aligned address
// Notes:   Answer one cycle after the request; bytes of other blocks read zero
`timescale 1ns/1ps
`include "pmcap_map.svh"
module pmcap_rd (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire pmcap_pkg::pmcap_addr_t cfg_addr,
    pmcap_if.rd_mp cif,
    output pmcap_pkg::pmcap_dword_t cfg_rdata,
    output logic cfg_ack,
    output logic cfg_hit
);
    import pmcap_pkg::*;

    pmcap_dword_t rdata_r;
    pmcap_dword_t rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic hit_r;
    logic hit_nxt;
    logic [5:0] dw;

    assign dw = cfg_addr[7:2];

    always_comb begin
        rdata_nxt = rdata_r;
        ack_nxt = cfg_rd | cfg_wr;
        hit_nxt = 1'b0;
        if (cfg_rd) begin
            rdata_nxt = '0;
            if (dw == `PMCAP_DW_LATENCY) begin
                rdata_nxt[`PMCAP_LANE_LATENCY +: 8] = cif.latency;
                hit_nxt = 1'b1;
            end else if (dw == `PMCAP_DW_CAP) begin
                rdata_nxt[`PMCAP_LANE_CAP_HDR +: 16] = cif.hdr;
                rdata_nxt[`PMCAP_LANE_CAPS +: 16] = cif.caps;
                hit_nxt = 1'b1;
            end
        end else if (cfg_wr) begin
            // Writes are acknowledged and dropped
            hit_nxt = (dw == `PMCAP_DW_LATENCY) || (dw == `PMCAP_DW_CAP);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            hit_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign cfg_rdata = rdata_r;
    assign cfg_ack = ack_r;
    assign cfg_hit = hit_r;

    property p_rd_cap;
        @(posedge clk) disable iff (sys_rst)
        (cfg_rd && dw == `PMCAP_DW_CAP)
            |=> cfg_ack && cfg_hit && cfg_rdata == {$past(cif.caps), $past(cif.hdr)};
    endproperty
    a_rd_cap: assert property (p_rd_cap)
        else $error("capability dword read returned wrong data");
endmodule // pmcap_rd

/* File: verification/pmcap_host.sv */
// Purpose: Host bridge model issuing configuration reads and writes
// Assumes: Requests are taken on the edge where the strobe is high
// Notes:   Address is scrambled after release so stale values never help
`timescale 1ns/1ps
module pmcap_host (
    input wire logic clk,
    output logic cfg_rd,
    output logic cfg_wr,
    output pmcap_pkg::pmcap_addr_t cfg_addr,
    input wire pmcap_pkg::pmcap_dword_t cfg_rdata,
    input wire logic cfg_ack,
    input wire logic cfg_hit
);
    import pmcap_pkg::*;

    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'hFF;
    end

    // One request, answer looked at in its single valid cycle
    task automatic access(input logic wr, input pmcap_addr_t a, output pmcap_dword_t d,
                          output logic ack, output logic hit);
        @(posedge clk);
        cfg_rd <= !wr;
        cfg_wr <= wr;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        @(negedge clk);
        d = cfg_rdata;
        ack = cfg_ack;
        hit = cfg_hit;
    endtask
endmodule // pmcap_host

/* File: verification/smartcard_pm_capability_regs_bench.sv */
// Purpose: Self-checking bench of the power capability bank
// Assumes: Host model drives the config bus, bench drives loader and control bit
// Notes:   Expected words are built from the fixed field values of the bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module smartcard_pm_capability_regs_bench;
    import pmcap_pkg::*;
    logic clk;
    logic sys_rst;
    logic cfg_rd;
    logic cfg_wr;
    pmcap_addr_t cfg_addr;
    pmcap_dword_t cfg_rdata;
    logic cfg_ack;
    logic cfg_hit;
    logic eeprom_lat_load;
    pmcap_byte_t eeprom_lat_data;
    logic gctrl_wr;
    logic gctrl_cold_wake_data;
    logic cold_wake_enable_ctrl;
    logic wake_from_cold_state_capable;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    pmcap_dword_t rd_d;
    logic rd_ack;
    logic rd_hit;

    pmcap_top uut (
        .clk(clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
        .eeprom_lat_load(eeprom_lat_load), .eeprom_lat_data(eeprom_lat_data),
        .gctrl_wr(gctrl_wr), .gctrl_cold_wake_data(gctrl_cold_wake_data),
        .cold_wake_enable_ctrl(cold_wake_enable_ctrl),
        .wake_from_cold_state_capable(wake_from_cold_state_capable)
    );

    pmcap_host host (
        .clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Far more than the sequence needs; a hang ends here
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic chk_rd(input pmcap_addr_t a, input pmcap_dword_t exp, input logic hit);
        host.access(1'b0, a, rd_d, rd_ack, rd_hit);
        `CHK(rd_ack, 1'b1)
        `CHK(rd_hit, hit)
        `CHK(rd_d, exp)
    endtask

    task automatic wr(input pmcap_addr_t a);
        host.access(1'b1, a, rd_d, rd_ack, rd_hit);
        `CHK(rd_ack, 1'b1)
        `CHK(rd_hit, 1'b1)
    endtask

    task automatic set_cold(input logic v);
        @(posedge clk);
        gctrl_wr <= 1'b1;
        gctrl_cold_wake_data <= v;
        @(posedge clk);
        gctrl_wr <= 1'b0;
        gctrl_cold_wake_data <= ~v;
        @(negedge clk);
        `CHK(cold_wake_enable_ctrl, v)
        `CHK(wake_from_cold_state_capable, v)
    endtask

    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    initial begin
        sys_rst = 1'b1;
        eeprom_lat_load = 1'b0;
        eeprom_lat_data = 8'h00;
        gctrl_wr = 1'b0;
        gctrl_cold_wake_data = 1'b0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        chk_rd(8'h3C, 32'h0004_0000, 1'b1);
        chk_rd(8'h44, 32'h7E02_0001, 1'b1);
        chk_rd(8'h46, 32'h7E02_0001, 1'b1);
        `CHK(cold_wake_enable_ctrl, 1'b0)
        chk_rd(8'h48, 32'h0000_0000, 1'b0);
        // Writes must leave every owned lane alone
        wr(8'h3C);
        wr(8'h3E);
        wr(8'h44);
        wr(8'h46);
        chk_rd(8'h3C, 32'h0004_0000, 1'b1);
        chk_rd(8'h44, 32'h7E02_0001, 1'b1);
        set_cold(1'b1);
        chk_rd(8'h44, 32'hFE42_0001, 1'b1);
        wr(8'h46);
        chk_rd(8'h46, 32'hFE42_0001, 1'b1);
        set_cold(1'b0);
        chk_rd(8'h44, 32'h7E02_0001, 1'b1);
        set_cold(1'b1);
        do_reset();
        `CHK(cold_wake_enable_ctrl, 1'b0)
        chk_rd(8'h44, 32'h7E02_0001, 1'b1);
        // Loader strobes back to back; the last byte wins
        @(posedge clk);
        eeprom_lat_load <= 1'b1;
        eeprom_lat_data <= 8'hAA;
        @(posedge clk);
        eeprom_lat_data <= 8'h55;
        @(posedge clk);
        eeprom_lat_load <= 1'b0;
        eeprom_lat_data <= 8'hAA;
        chk_rd(8'h3E, 32'h0055_0000, 1'b1);
        wr(8'h3E);
        chk_rd(8'h3C, 32'h0055_0000, 1'b1);
        do_reset();
        chk_rd(8'h3C, 32'h0004_0000, 1'b1);
        test_done();
    end
endmodule // smartcard_pm_capability_regs_bench
